// File: hdl/pss_pkg.sv
// Purpose: Shared constants and types for the pipelined sync SRAM port.
// Assumes: Four lanes of eight data bits plus one parity bit each.
// Notes: Lane L holds data in bits 9L+7..9L and parity in bit 9L+8.
package pss_pkg;
   localparam int ADDR_W = 18;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int BYTE_W = 8;
   localparam int PAR_BIT = 8;
   localparam int DATA_W = LANES * LANE_W;
   localparam int SYNC_W = 4;
   localparam logic [1:0] BEAT_ONE = 2'h1;
   localparam logic [1:0] BEAT_ZERO = 2'h0;
   localparam logic [1:0] STRAP_WAIT = 2'h3;
   localparam logic [1:0] STRAP_ZERO = 2'h0;
   // Synchroniser reset: output enable off, no snooze, interleaved, normal.
   localparam logic [SYNC_W-1:0] SYNC_RST = 4'hD;
   localparam int SY_OEN = 0;
   localparam int SY_SNZ = 1;
   localparam int SY_ORDER = 2;
   localparam int SY_ADAPT = 3;
   localparam logic ORDER_LINEAR = 1'h0;
   localparam logic ORDER_INTERLEAVED = 1'h1;
   localparam logic ADAPT_ON_N = 1'h0;
   localparam logic ADAPT_OFF_N = 1'h1;

   typedef enum logic [1:0] {
      PSS_DESEL = 2'b00,
      PSS_READ = 2'b01,
      PSS_WRITE = 2'b10,
      PSS_BURST = 2'b11
   } pss_cmd_t;

   // One pipelined access: selected, read, word address, lane enables.
   typedef struct packed {
      logic sel;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0] bwN;
   } pss_stage_t;

   localparam pss_stage_t STAGE_IDLE = '{1'h0, 1'h0, 18'h00000, 4'hF};
endpackage

// File: hdl/pss_sram_port.sv
// Purpose: Control logic and array of a pipelined synchronous SRAM.
// Assumes: The controller runs on mclk; output enable, snooze and
// Assumes: the two straps are asynchronous and are synchronised here.
// Notes: Data follows its address by two enabled clock edges.
`timescale 1ns/100ps

// Operation
// - Address, data, chip enables, lane enables, burst control sampled each edge.
// - Load/advance low loads a new address into address register and counter.
// - Load/advance high advances the burst counter and ignores read/write select.
// - Read/write select at a load cycle alone decides read or write.
// - A burst keeps its direction until a new address is loaded.
// - Lane write enables are active low and gate only their own lane.
// - Each lane enable covers the lane byte and its parity bit.
// - Parity bits exist only in parity builds; otherwise never driven or stored.
// - Low enables write their lanes; all high makes the write a no-op.
// - Selected only with both low enables low and high enable high.
// - Clock enable inactive stretches the previous cycle with no change.
// - A stalled cycle leaves the command state untouched.
// - Command state moves only on clock edges among four states.
// - Output enable gates the data drivers independent of commands.
// - Snooze ignores all other inputs, keeps the array, floats the bus.
// - Order strap low means linear, high means interleaved; held static.
// - Timing strap low selects adaptive turn-on, high normal; held static.
// - Interleaved beats use start bits XOR beat count.
// - Linear beats add beat count to start bits modulo four.
// - Continue cycles keep the operation chosen by the begin cycle.
// - Two-bit burst counter steps each continue cycle, wraps every fourth.
// - Data drivers stay off during write cycles.
// - Continue-deselect only follows a deselect cycle.
module pss_sram_port #(
   parameter bit PARITY_EN = 1'b1, // Parity bits present.
   parameter int unsigned LANE_CNT = 4 // Lanes in use, 2 or 4.
) (
   input wire logic mclk, // System clock.
   input wire logic reset, // Asynchronous reset, active high.
   input wire logic [pss_pkg::ADDR_W-1:0] syncAddrIn, // Word address.
   input wire logic advanceOrLoad, // High advances, low loads.
   input wire logic rdWrSel, // High read, low write.
   input wire logic [pss_pkg::LANES-1:0] byteWrEnN, // Lane enables.
   input wire logic chipSelFirstN, // Chip select, active low.
   input wire logic chipSelSecondN, // Chip select, active low.
   input wire logic chipSelThird, // Chip select, active high.
   input wire logic clkEnN, // Clock enable, active low.
   input wire logic outEnN, // Output enable, active low, async.
   input wire logic snoozeReq, // Standby request, async.
   input wire logic burstOrderSel, // Strap: low linear.
   input wire logic adaptiveTimingSelN, // Strap: low adaptive.
   input wire logic [pss_pkg::DATA_W-1:0] dataIn, // Bus level in.
   output logic [pss_pkg::DATA_W-1:0] dataOut, // Bus drive value.
   output logic [pss_pkg::DATA_W-1:0] dataOe, // Bus drive enable.
   output logic adaptiveModeOn, // Adaptive turn-on in force.
   output pss_pkg::pss_cmd_t cmdState // Command state.
);

   localparam int DEPTH = 2 ** pss_pkg::ADDR_W;

   // Bits that a lane may store and drive in this build.
   function automatic logic [pss_pkg::DATA_W-1:0] laneMask(
      input logic par,
      input int unsigned lanes
   );
      logic [pss_pkg::DATA_W-1:0] m;
      m = '0;
      for (int l = 0; l < pss_pkg::LANES; l++) begin
         if (l < int'(lanes)) begin
            m[l*pss_pkg::LANE_W +: pss_pkg::BYTE_W] = '1;
            m[l*pss_pkg::LANE_W + pss_pkg::PAR_BIT] = par;
         end
      end
      return m;
   endfunction

   // Low address bits of a burst beat.
   function automatic logic [1:0] beatLow(
      input logic [1:0] start,
      input logic [1:0] beat,
      input logic order
   );
      if (order == pss_pkg::ORDER_LINEAR) begin
         return 2'(start + beat);
      end
      return start ^ beat;
   endfunction

   localparam logic [pss_pkg::DATA_W-1:0] MASK =
      laneMask(PARITY_EN, LANE_CNT);

   logic [pss_pkg::SYNC_W-1:0] asyncIn;
   logic [pss_pkg::SYNC_W-1:0] meta_ff;
   logic [pss_pkg::SYNC_W-1:0] sync_ff;
   logic oeNSync;
   logic snzSync;
   logic [1:0] strapCnt_ff;
   logic order_ff;
   // High when the timing strap asked for adaptive turn-on at capture.
   logic adapt_ff;
   logic active;
   logic loadCyc;
   logic selNow;
   pss_pkg::pss_cmd_t cmdState_ff;
   pss_pkg::pss_cmd_t nxt_cmdState;
   logic [pss_pkg::ADDR_W-1:0] base_ff;
   logic [1:0] beat_ff;
   logic [1:0] nxt_beat;
   logic opSel_ff;
   logic opRd_ff;
   pss_pkg::pss_stage_t stage1_ff;
   pss_pkg::pss_stage_t stage2_ff;
   pss_pkg::pss_stage_t nxt_stage1;
   logic busRead_ff;
   logic nxt_busRead;
   logic [pss_pkg::DATA_W-1:0] dataOut_ff;
   logic [pss_pkg::DATA_W-1:0] dataOe_ff;
   logic [pss_pkg::DATA_W-1:0] mem [DEPTH];

   assign asyncIn = {adaptiveTimingSelN, burstOrderSel, snoozeReq, outEnN};

   // Two-stage synchroniser for the asynchronous pins and straps.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         meta_ff <= pss_pkg::SYNC_RST;
         sync_ff <= pss_pkg::SYNC_RST;
      end else begin
         meta_ff <= asyncIn;
         sync_ff <= meta_ff;
      end
   end

   assign oeNSync = sync_ff[pss_pkg::SY_OEN];
   assign snzSync = sync_ff[pss_pkg::SY_SNZ];

   // Straps are followed for the first three edges after reset, until the synchroniser
   // has settled, and are not followed afterwards.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         strapCnt_ff <= pss_pkg::STRAP_ZERO;
         order_ff <= pss_pkg::ORDER_INTERLEAVED;
         adapt_ff <= 1'b0;
      end else if (strapCnt_ff != pss_pkg::STRAP_WAIT) begin
         strapCnt_ff <= 2'(strapCnt_ff + pss_pkg::BEAT_ONE);
         order_ff <= sync_ff[pss_pkg::SY_ORDER];
         adapt_ff <= (sync_ff[pss_pkg::SY_ADAPT]
            == pss_pkg::ADAPT_ON_N);
      end
   end

   // An edge counts only with clock enable low and no snooze.
   assign active = ~clkEnN & ~snzSync;
   assign loadCyc = ~advanceOrLoad;
   assign selNow = ~chipSelFirstN & ~chipSelSecondN & chipSelThird;

   always_comb begin
      nxt_cmdState = cmdState_ff;
      nxt_beat = beat_ff;
      nxt_stage1 = pss_pkg::STAGE_IDLE;
      if (loadCyc) begin
         nxt_beat = pss_pkg::BEAT_ZERO;
         if (selNow) begin
            nxt_cmdState = rdWrSel ? pss_pkg::PSS_READ
                                   : pss_pkg::PSS_WRITE;
            nxt_stage1.sel = 1'b1;
            nxt_stage1.rd = rdWrSel;
            nxt_stage1.addr = syncAddrIn;
         end else begin
            nxt_cmdState = pss_pkg::PSS_DESEL;
         end
      end else begin
         // Continue cycle: direction and selection come from the load.
         nxt_cmdState = pss_pkg::PSS_BURST;
         nxt_beat = 2'(beat_ff + pss_pkg::BEAT_ONE);
         nxt_stage1.sel = opSel_ff;
         nxt_stage1.rd = opRd_ff;
         nxt_stage1.addr = {base_ff[pss_pkg::ADDR_W-1:2],
                            beatLow(base_ff[1:0], nxt_beat, order_ff)};
      end
      nxt_stage1.bwN = byteWrEnN;
   end

   // Command state, burst counter and the operation of the burst.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         cmdState_ff <= pss_pkg::PSS_DESEL;
         beat_ff <= pss_pkg::BEAT_ZERO;
         base_ff <= '0;
         opSel_ff <= 1'b0;
         opRd_ff <= 1'b0;
      end else if (active) begin
         cmdState_ff <= nxt_cmdState;
         beat_ff <= nxt_beat;
         if (loadCyc) begin
            base_ff <= syncAddrIn;
            opSel_ff <= selNow;
            opRd_ff <= rdWrSel;
         end
      end
   end

   // Two-stage address pipeline in front of the data phase.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         stage1_ff <= pss_pkg::STAGE_IDLE;
         stage2_ff <= pss_pkg::STAGE_IDLE;
      end else if (active) begin
         stage1_ff <= nxt_stage1;
         stage2_ff <= stage1_ff;
      end
   end

   // Array writes take bus data two enabled edges after the address.
   always_ff @(posedge mclk) begin
      if (active && stage2_ff.sel && !stage2_ff.rd) begin
         for (int l = 0; l < pss_pkg::LANES; l++) begin
            if (!stage2_ff.bwN[l]) begin
               mem[stage2_ff.addr][l*pss_pkg::LANE_W +: pss_pkg::LANE_W]
                  <= dataIn[l*pss_pkg::LANE_W +: pss_pkg::LANE_W]
                     & MASK[l*pss_pkg::LANE_W +: pss_pkg::LANE_W];
            end
         end
      end
   end

   // Read data holds through stalls; snooze ends the drive at once.
   always_comb begin
      nxt_busRead = busRead_ff;
      if (snzSync) begin
         nxt_busRead = 1'b0;
      end else if (!clkEnN) begin
         nxt_busRead = stage2_ff.sel & stage2_ff.rd;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         busRead_ff <= 1'b0;
         dataOut_ff <= '0;
         dataOe_ff <= '0;
      end else begin
         busRead_ff <= nxt_busRead;
         if (active && stage2_ff.sel && stage2_ff.rd) begin
            dataOut_ff <= mem[stage2_ff.addr] & MASK;
         end
         dataOe_ff <= (nxt_busRead && !oeNSync) ? MASK : '0;
      end
   end

   assign dataOut = dataOut_ff;
   assign dataOe = dataOe_ff;
   assign adaptiveModeOn = adapt_ff;
   assign cmdState = cmdState_ff;

   default clocking cbk @(posedge mclk);
   endclocking
   default disable iff (reset);

   logic loadSel;
   logic contOk;
   assign loadSel = active & loadCyc & selNow;
   assign contOk = active & advanceOrLoad;

   property p_stall_hold;
      (clkEnN && !snzSync && busRead_ff && !oeNSync) |=>
         dataOe_ff == MASK && $stable(dataOut_ff);
   endproperty
   a_stall_hold: assert property (p_stall_hold)
      else $error("Read data dropped on a stalled edge");

   property p_stall_state;
      (clkEnN && !snzSync) |=> $stable(cmdState_ff) && $stable(beat_ff)
         && $stable(stage2_ff);
   endproperty
   a_stall_state: assert property (p_stall_state)
      else $error("State changed on a stalled edge");

   property p_load_addr;
      (active && loadCyc) |=> base_ff == $past(syncAddrIn)
         && beat_ff == pss_pkg::BEAT_ZERO;
   endproperty
   a_load_addr: assert property (p_load_addr)
      else $error("Load cycle did not capture the address");

   property p_load_dir;
      loadSel |=> cmdState_ff == ($past(rdWrSel) ? pss_pkg::PSS_READ
                                                : pss_pkg::PSS_WRITE);
   endproperty
   a_load_dir: assert property (p_load_dir)
      else $error("Load cycle took the wrong direction");

   property p_desel;
      (active && loadCyc && !selNow) |=> cmdState_ff == pss_pkg::PSS_DESEL
         && !stage1_ff.sel;
   endproperty
   a_desel: assert property (p_desel)
      else $error("Unselected load did not deselect");

   property p_cont_dir;
      contOk |=> stage1_ff.rd == opRd_ff && stage1_ff.sel == opSel_ff
         && beat_ff == 2'($past(beat_ff) + pss_pkg::BEAT_ONE);
   endproperty
   a_cont_dir: assert property (p_cont_dir)
      else $error("Continue cycle changed direction or count");

   property p_interleave;
      (loadSel && order_ff == pss_pkg::ORDER_INTERLEAVED) ##1 contOk
         |=> stage1_ff.addr[1:0] ==
            ($past(syncAddrIn[1:0], 2) ^ pss_pkg::BEAT_ONE);
   endproperty
   a_interleave: assert property (p_interleave)
      else $error("Interleaved beat address wrong");

   property p_linear;
      (loadSel && order_ff == pss_pkg::ORDER_LINEAR) ##1 contOk ##1 contOk
         |=> stage1_ff.addr[1:0] ==
            2'($past(syncAddrIn[1:0], 3) + 2'h2);
   endproperty
   a_linear: assert property (p_linear)
      else $error("Linear beat address wrong");

   property p_read_lat;
      (loadSel && rdWrSel && !oeNSync) ##1 (active && !oeNSync)
         ##1 (active && !oeNSync) |=> dataOe_ff == MASK;
   endproperty
   a_read_lat: assert property (p_read_lat)
      else $error("Read data not driven two edges after address");

   property p_write_off;
      (active && stage2_ff.sel && !stage2_ff.rd) |=> dataOe_ff == '0;
   endproperty
   a_write_off: assert property (p_write_off)
      else $error("Drivers on during a write");

   property p_snooze_off;
      snzSync |=> dataOe_ff == '0 && $stable(cmdState_ff);
   endproperty
   a_snooze_off: assert property (p_snooze_off)
      else $error("Snooze left the bus driven or moved state");

   property p_oe_off;
      oeNSync |=> dataOe_ff == '0;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("Bus driven with output enable inactive");

   property p_wrap;
      (contOk && &beat_ff) |=> beat_ff == pss_pkg::BEAT_ZERO
         && stage1_ff.addr == base_ff;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("Burst did not wrap to its first address");

   property p_desel_float;
      (active && !stage2_ff.sel) |=> dataOe_ff == '0;
   endproperty
   a_desel_float: assert property (p_desel_float)
      else $error("Bus driven in a cycle with no access");

   property p_strap_hold;
      strapCnt_ff == pss_pkg::STRAP_WAIT |=> $stable(order_ff)
         && $stable(adapt_ff);
   endproperty
   a_strap_hold: assert property (p_strap_hold)
      else $error("Strap setting moved after capture");

   property p_cont_state;
      contOk |=> cmdState_ff == pss_pkg::PSS_BURST;
   endproperty
   a_cont_state: assert property (p_cont_state)
      else $error("Continue cycle did not enter burst state");

   c_read: cover property (loadSel && rdWrSel ##1 contOk[*3]);
   c_write: cover property (loadSel && !rdWrSel ##1 contOk ##1 contOk);
   c_stall: cover property (busRead_ff && clkEnN ##1 dataOe_ff == MASK);
   c_turn: cover property (loadSel && rdWrSel ##1 loadSel && !rdWrSel);

endmodule // pss_sram_port

// File: testbench/pss_ctl_model.sv
// Purpose: Bus side of the controller that faces the SRAM port.
// Assumes: The bench says when and what write data the controller drives.
// Notes: A floating bus shows the inverse of its last level.
`timescale 1ns/100ps
module pss_ctl_model (
   input wire logic mclk, // System clock.
   input wire logic [35:0] dataOut, // Device drive value.
   input wire logic [35:0] dataOe, // Device drive enable.
   input wire logic [35:0] wrData, // Controller write data.
   input wire logic wrDrive, // Controller drives the bus.
   output logic [35:0] dataIn // Resolved bus level.
);
   logic [35:0] lastBus = 36'h000000000;

   always_ff @(posedge mclk) begin
      lastBus <= dataIn;
   end

   // Nobody driving must not look like held data, so the bus flips.
   always_comb begin
      dataIn = (dataOe & dataOut) |
         (~dataOe & (wrDrive ? wrData : ~lastBus));
   end
endmodule // pss_ctl_model

// File: testbench/tb_top.sv
// Purpose: Self-checking bench for the pipelined sync SRAM port.
// Assumes: Commands are issued one per clock by the step task.
// Notes: A four-deep history tracks commands until their data is due.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
   num_errors++; $display("mismatch %s expected %h seen %h", nm, ex, got); \
   end end
module tb_top;
   logic mclk = 1'h0;
   logic reset = 1'h1;
   logic [17:0] syncAddrIn = 18'h00000;
   logic advanceOrLoad = 1'h0, rdWrSel = 1'h1, clkEnN = 1'h0;
   logic [3:0] byteWrEnN = 4'hF;
   logic chipSelFirstN = 1'h1, chipSelSecondN = 1'h0, chipSelThird = 1'h1;
   logic outEnN = 1'h0, snoozeReq = 1'h0, wrDrive = 1'h0;
   logic burstOrderSel = 1'h0, adaptiveTimingSelN = 1'h0, adaptiveModeOn;
   logic [35:0] dataIn, dataOut, dataOe, wrData = 36'h000000000;
   pss_pkg::pss_cmd_t cmdState;
   int num_errors = 0, compares = 0, serial = 0;
   logic oeV = 1'h0, zzV = 1'h0, oeOff = 1'h0, snz = 1'h0, stallPrev;
   logic [17:0] curBase;
   logic [1:0] curBeat;
   logic curRd, curSel;
   pss_pkg::pss_stage_t hs [4];
   pss_pkg::pss_cmd_t hc [4];
   logic [35:0] hd [4];
   logic [35:0] mem [logic [17:0]];
   logic [2:0] dsel [3] = '{3'h5, 3'h3, 3'h0};

   initial begin
      forever #5 mclk = ~mclk;
   end

   pss_sram_port #(.PARITY_EN(1'b1), .LANE_CNT(4)) u_pss_sram_port (
      .mclk(mclk), .reset(reset), .syncAddrIn(syncAddrIn),
      .advanceOrLoad(advanceOrLoad), .rdWrSel(rdWrSel),
      .byteWrEnN(byteWrEnN), .chipSelFirstN(chipSelFirstN),
      .chipSelSecondN(chipSelSecondN), .chipSelThird(chipSelThird),
      .clkEnN(clkEnN), .outEnN(outEnN), .snoozeReq(snoozeReq),
      .burstOrderSel(burstOrderSel),
      .adaptiveTimingSelN(adaptiveTimingSelN), .dataIn(dataIn),
      .dataOut(dataOut), .dataOe(dataOe),
      .adaptiveModeOn(adaptiveModeOn), .cmdState(cmdState));

   pss_ctl_model u_pss_ctl_model (.mclk(mclk), .dataOut(dataOut),
      .dataOe(dataOe), .wrData(wrData), .wrDrive(wrDrive),
      .dataIn(dataIn));

   task automatic stop_test;
      $display("checks %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Issues one command; stl stalls the next edge, cs is {cs1N,cs2N,cs3}.
   task automatic step(input logic ld, input logic r, input logic [17:0] a,
         input logic [3:0] bw, input logic [2:0] cs, input logic stl);
      logic [1:0] lo;
      @(posedge mclk);
      advanceOrLoad <= ld;
      rdWrSel <= r;
      syncAddrIn <= a;
      byteWrEnN <= bw;
      {chipSelFirstN, chipSelSecondN, chipSelThird} <= cs;
      clkEnN <= stl;
      outEnN <= oeV;
      snoozeReq <= zzV;
      if (!stallPrev) begin
         for (int i = 3; i > 0; i--) begin
            hs[i] = hs[i-1];
            hc[i] = hc[i-1];
            hd[i] = hd[i-1];
         end
      end
      hs[0] = pss_pkg::STAGE_IDLE;
      hc[0] = hc[1];
      if (!stl && !snz) begin
         if (!ld) begin
            curSel = (cs == 3'h1);
            curRd = r;
            curBase = a;
            curBeat = 2'h0;
            hc[0] = !curSel ? pss_pkg::PSS_DESEL :
               (r ? pss_pkg::PSS_READ : pss_pkg::PSS_WRITE);
         end else begin
            curBeat = curBeat + 2'h1;
            hc[0] = pss_pkg::PSS_BURST;
         end
         lo = burstOrderSel ? curBase[1:0] ^ curBeat :
            curBase[1:0] + curBeat;
         hs[0] = '{curSel, curRd, {curBase[17:2], lo}, bw};
         serial++;
         hd[0] = {serial[17:0], ~serial[17:0]};
      end
      stallPrev = stl;
      wrDrive <= hs[2].sel && !hs[2].rd;
      wrData <= hd[2];
      if (hs[2].sel && !hs[2].rd) begin
         for (int l = 0; l < 4; l++) begin
            if (!hs[2].bwN[l]) begin
               mem[hs[2].addr][9*l +: 9] = hd[2][9*l +: 9];
            end
         end
      end
      #1;
      `CHK("cmdState", hc[1], cmdState)
      if (hs[3].sel && hs[3].rd && !oeOff) begin
         `CHK("dataOe", 36'hFFFFFFFFF, dataOe)
         `CHK("dataOut", mem[hs[3].addr], dataOut)
      end else begin
         `CHK("dataOe", 36'h000000000, dataOe)
      end
   endtask

   task automatic idle(input int n);
      repeat (n) step(1'h0, 1'h1, 18'h00000, 4'hF, 3'h4, 1'h0);
   endtask

   task automatic run(input logic ord);
      @(posedge mclk);
      reset <= 1'h1;
      burstOrderSel <= ord;
      adaptiveTimingSelN <= ord;
      repeat (2) @(posedge mclk);
      reset <= 1'h0;
      for (int i = 0; i < 4; i++) begin
         hs[i] = pss_pkg::STAGE_IDLE;
         hc[i] = pss_pkg::PSS_DESEL;
      end
      stallPrev = 1'h0;
      curSel = 1'h0;
      idle(4);
      `CHK("adaptiveModeOn", ~ord, adaptiveModeOn)
      step(1'h0, 1'h0, 18'h00106, 4'h0, 3'h1, 1'h0);
      repeat (4) step(1'h1, 1'h1, 18'h3FFFF, 4'h0, 3'h1, 1'h0);
      step(1'h0, 1'h0, 18'h00200, 4'h0, 3'h1, 1'h0);
      step(1'h0, 1'h1, 18'h00107, 4'hF, 3'h1, 1'h0);
      step(1'h1, 1'h0, 18'h00000, 4'h0, 3'h1, 1'h0);
      step(1'h1, 1'h0, 18'h00000, 4'h0, 3'h1, 1'h0);
      step(1'h0, 1'h0, 18'h00105, 4'h0, 3'h1, 1'h1);
      step(1'h1, 1'h0, 18'h00000, 4'h0, 3'h1, 1'h0);
      step(1'h0, 1'h1, 18'h00200, 4'hF, 3'h1, 1'h0);
      idle(3);
      for (int l = 0; l < 4; l++) begin
         step(1'h0, 1'h0, 18'h00300, ~(4'h1 << l), 3'h1, 1'h0);
      end
      step(1'h0, 1'h0, 18'h00300, 4'hF, 3'h1, 1'h0);
      idle(2);
      step(1'h0, 1'h1, 18'h00300, 4'hF, 3'h1, 1'h0);
      for (int k = 0; k < 3; k++) begin
         step(1'h0, 1'h1, 18'h00106, 4'hF, dsel[k], 1'h0);
         step(1'h1, 1'h1, 18'h00106, 4'hF, 3'h1, 1'h0);
      end
      oeV = 1'h1;
      idle(4);
      oeOff = 1'h1;
      step(1'h0, 1'h1, 18'h00300, 4'hF, 3'h1, 1'h0);
      idle(3);
      oeV = 1'h0;
      idle(4);
      oeOff = 1'h0;
      zzV = 1'h1;
      idle(4);
      snz = 1'h1;
      repeat (3) step(1'h0, 1'h0, 18'h00300, 4'h0, 3'h1, 1'h0);
      zzV = 1'h0;
      idle(4);
      snz = 1'h0;
      step(1'h0, 1'h1, 18'h00300, 4'hF, 3'h1, 1'h0);
      idle(3);
      $display("test with order strap %0d done", ord);
   endtask

   initial begin
      run(1'h0);
      run(1'h1);
      stop_test();
   end

   initial begin
      repeat (5000) @(posedge mclk);
      num_errors++;
      $display("watchdog expired before the tests ended");
      stop_test();
   end
endmodule // tb_top
